// >>> design/multi_queue_flow_fifo.sv
// multi_queue_flow_fifo: up to four queues over one pool, fall-through read
// assumes config pins are steady around master reset release
`timescale 1ns/100ps
`default_nettype none

module multi_queue_flow_fifo (
   input  wire logic                                        mclk_in,
   input  wire logic                                        nrst_in,
   input  wire logic                                        cfg_default_in,
   input  wire logic [mq_fifo_pkg::NQ_W-1:0]                cfg_queues_in,
   input  wire logic [3:0][mq_fifo_pkg::BLK_W-1:0]          cfg_blocks_in,
   input  wire logic [3:0][mq_fifo_pkg::PTR_W-1:0]          cfg_ae_level_in,
   input  wire logic [3:0][mq_fifo_pkg::PTR_W-1:0]          cfg_af_level_in,
   input  wire logic                                        in_wide_in,
   input  wire logic                                        out_wide_in,
   input  wire logic [mq_fifo_pkg::DEV_W-1:0]               device_id_in,
   input  wire logic [mq_fifo_pkg::DEV_W-1:0]               write_device_select_in,
   input  wire logic [mq_fifo_pkg::DEV_W-1:0]               read_device_select_in,
   input  wire logic                                        wr_en_in,
   input  wire logic [mq_fifo_pkg::QSEL_W-1:0]              write_queue_select_in,
   input  wire logic [mq_fifo_pkg::DATA_W-1:0]              wr_data_in,
   input  wire logic                                        rd_en_in,
   input  wire logic [mq_fifo_pkg::QSEL_W-1:0]              read_queue_select_in,
   input  wire logic                                        single_queue_reset_in,
   output logic                                             config_done_out,
   output logic [mq_fifo_pkg::DATA_W-1:0]                   rd_data_out,
   output logic                                             output_valid_flag_out,
   output logic                                             write_queue_full_flag_out,
   output logic                                             almost_full_flag_out,
   output logic                                             almost_empty_flag_out,
   output logic [3:0]                                       almost_full_flag_bus_out,
   output logic [3:0]                                       almost_empty_flag_bus_out,
   output logic [mq_fifo_pkg::PTR_W-1:0]                    block_words_out
);
   import mq_fifo_pkg::*;

   typedef struct packed {
      phase_t           phase;
      logic             in_wide;
      logic             out_wide;
      logic [DEV_W-1:0] dev_id;
      logic [NQ_W-1:0]  nq;
      bvec_t            blocks;
      qvec_t            ae_lvl;
      qvec_t            af_lvl;
      qvec_t            wptr;
      qvec_t            rptr;
      qvec_t            cnt;
      logic [DATA_W-1:0] rd_data;
      logic             ov;
      logic [QSEL_W-1:0] rdq;
      logic             full;
      logic             af_sel;
      logic             ae_sel;
      logic [NUM_Q-1:0] afb;
      logic [NUM_Q-1:0] aeb;
      logic [PTR_W-1:0] blk_words;
   } state_t;

   state_t              s_ff;
   state_t              nxt_s;
   logic [DATA_W-1:0]   mem [POOL_WORDS];
   logic [QSEL_W-1:0]   wq;
   logic [QSEL_W-1:0]   rq;
   logic [PTR_W-1:0]    wbytes;
   logic [PTR_W-1:0]    rbytes;
   logic [PTR_W-1:0]    waddr;
   logic [PTR_W-1:0]    raddr;
   logic [PTR_W-1:0]    rhead;
   logic [PTR_W-1:0]    cnt_w;
   logic [DATA_W-1:0]   rword;
   logic [DATA_W-1:0]   mem_wdata;
   logic [1:0]          mem_we;
   logic                wr_try;
   logic                wr_ok;
   logic                pop;
   logic                single_queue_reset;
   logic                avail;

   qstat_if qs ();

   queue_layout u_layout (
      .qs (qs.layout)
   );

   queue_flags u_flags (
      .qs (qs.flags)
   );

   assign qs.nq     = s_ff.nq;
   assign qs.blocks = s_ff.blocks;
   assign qs.cnt    = s_ff.cnt;
   assign qs.ae_lvl = s_ff.ae_lvl;
   assign qs.af_lvl = s_ff.af_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // port steering and pool addressing

   assign wq     = write_queue_select_in;
   assign rq     = read_queue_select_in;
   assign wbytes = unit_bytes(s_ff.in_wide);
   assign rbytes = unit_bytes(s_ff.out_wide);
   assign cnt_w  = s_ff.cnt[wq];
   assign waddr  = qs.base[wq] + s_ff.wptr[wq];
   assign pop    = (s_ff.phase == PH_RUN) && rd_en_in && s_ff.ov &&
                   (read_device_select_in == s_ff.dev_id);
   // head after this edge's pop, worked out apart from nxt_s so no loop forms
   assign rhead  = (pop && (s_ff.rdq == rq)) ? step_ptr(s_ff.rptr[rq], rbytes, qs.cap[rq]) :
                                                s_ff.rptr[rq];
   assign raddr  = qs.base[rq] + rhead;
   assign rword  = mem[raddr[ADDR_W:1]];
   // a narrow write lands in the lane its byte address picks
   assign mem_wdata = s_ff.in_wide ? wr_data_in : {wr_data_in[BYTE_W-1:0], wr_data_in[BYTE_W-1:0]};

   always_comb begin
      mem_we = 2'b00;
      if (wr_ok) begin
         mem_we = s_ff.in_wide ? 2'b11 : (waddr[0] ? 2'b10 : 2'b01);
      end
   end

   // no reset on the pool: contents only matter once counted in
   always_ff @(posedge mclk_in) begin
      if (mem_we[0]) begin
         mem[waddr[ADDR_W:1]][BYTE_W-1:0] <= mem_wdata[BYTE_W-1:0];
      end
      if (mem_we[1]) begin
         mem[waddr[ADDR_W:1]][DATA_W-1:BYTE_W] <= mem_wdata[DATA_W-1:BYTE_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_s  = s_ff;
      wr_try = 1'b0;
      wr_ok  = 1'b0;
      single_queue_reset    = 1'b0;
      avail  = 1'b0;
      case (s_ff.phase)
         PH_CAPTURE: begin
            // pins read once, on the first edge after release
            nxt_s.in_wide  = in_wide_in;
            nxt_s.out_wide = out_wide_in;
            nxt_s.dev_id   = device_id_in;
            nxt_s.blk_words = block_words(in_wide_in, out_wide_in);
            if (cfg_default_in) begin
               nxt_s.nq     = DEFAULT_QUEUES;
               nxt_s.blocks = {NUM_Q{DEFAULT_BLOCKS}};
               nxt_s.ae_lvl = {NUM_Q{DEFAULT_AE}};
               nxt_s.af_lvl = {NUM_Q{DEFAULT_AF}};
            end else begin
               if (cfg_queues_in < MIN_QUEUES) begin
                  nxt_s.nq = MIN_QUEUES;
               end else if (cfg_queues_in > MAX_QUEUES) begin
                  nxt_s.nq = MAX_QUEUES;
               end else begin
                  nxt_s.nq = cfg_queues_in;
               end
               nxt_s.blocks = cfg_blocks_in;
               nxt_s.ae_lvl = cfg_ae_level_in;
               nxt_s.af_lvl = cfg_af_level_in;
            end
            nxt_s.phase = PH_RUN;
         end
         PH_RUN: begin
            // ports work independently, same queue allowed
            wr_try = wr_en_in && (write_device_select_in == s_ff.dev_id) &&
                     ({1'b0, wq} < s_ff.nq);
            // a write with too little room is dropped
            wr_ok  = wr_try && ((qs.cap[wq] - s_ff.cnt[wq]) >= wbytes);
            single_queue_reset    = single_queue_reset_in && (wq == rq);
            if (wr_ok) begin
               nxt_s.wptr[wq] = step_ptr(s_ff.wptr[wq], wbytes, qs.cap[wq]);
               nxt_s.cnt[wq]  = s_ff.cnt[wq] + wbytes;
            end
            if (pop) begin
               nxt_s.rptr[s_ff.rdq] = step_ptr(s_ff.rptr[s_ff.rdq], rbytes, qs.cap[s_ff.rdq]);
               nxt_s.cnt[s_ff.rdq]  = nxt_s.cnt[s_ff.rdq] - rbytes;
            end
            // fresh writes show up one edge later, so only stored bytes count
            avail = !single_queue_reset && ({1'b0, rq} < s_ff.nq) &&
                    ((s_ff.cnt[rq] - ((pop && (s_ff.rdq == rq)) ? rbytes : '0)) >= rbytes);
            if (single_queue_reset) begin
               nxt_s.wptr[wq] = '0;
               nxt_s.rptr[wq] = '0;
               nxt_s.cnt[wq]  = '0;
            end
            if (avail) begin
               // head word drops into the output unasked
               nxt_s.rd_data = s_ff.out_wide ? rword :
                               {ZERO_BYTE, (raddr[0] ? rword[DATA_W-1:BYTE_W] : rword[BYTE_W-1:0])};
               nxt_s.ov      = 1'b1;
               nxt_s.rdq     = rq;
            end else begin
               nxt_s.ov      = 1'b0;
            end
            nxt_s.full   = ({1'b0, wq} >= s_ff.nq) ||
                           ((qs.cap[wq] - nxt_s.cnt[wq]) < wbytes);
            nxt_s.af_sel = qs.af[wq];
            nxt_s.ae_sel = qs.ae[rq];
            nxt_s.afb    = qs.af;
            nxt_s.aeb    = qs.ae;
         end
         default: begin
            nxt_s.phase = PH_CAPTURE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign config_done_out           = (s_ff.phase == PH_RUN);
   assign rd_data_out               = s_ff.rd_data;
   assign output_valid_flag_out     = s_ff.ov;
   assign write_queue_full_flag_out = s_ff.full;
   assign almost_full_flag_out      = s_ff.af_sel;
   assign almost_empty_flag_out     = s_ff.ae_sel;
   assign almost_full_flag_bus_out  = s_ff.afb;
   assign almost_empty_flag_bus_out = s_ff.aeb;
   assign block_words_out           = s_ff.blk_words;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   AST_FULL_DROPS_WRITE: assert property (
      (wr_try && ((qs.cap[wq] - s_ff.cnt[wq]) < wbytes)) |-> (mem_we == 2'b00))
      else $error("write to a full queue reached the pool");

   AST_WRITE_GROWS: assert property (
      (wr_ok && !(pop && (s_ff.rdq == wq)) && !single_queue_reset)
      |=> (s_ff.cnt[$past(wq)] == $past(cnt_w) + $past(wbytes)))
      else $error("accepted write did not grow its queue");

   AST_VALID_HAS_DATA: assert property (
      output_valid_flag_out |-> (s_ff.cnt[s_ff.rdq] >= rbytes))
      else $error("valid shown for a queue without data");

   AST_EMPTY_KEEPS_WORD: assert property (
      (s_ff.phase == PH_RUN && !avail) |=> ($stable(rd_data_out) && !output_valid_flag_out))
      else $error("output word changed on an empty queue");

   AST_FALL_THROUGH: assert property (
      (s_ff.phase == PH_RUN && avail) |=> (output_valid_flag_out && (s_ff.rdq == $past(rq))))
      else $error("available word did not fall through");

   AST_PRS_CLEARS: assert property (
      single_queue_reset |=> (s_ff.cnt[$past(wq)] == '0) ##1 !almost_full_flag_bus_out[$past(wq, 2)])
      else $error("partial reset left data in the queue");

   AST_BUS_INACTIVE_QUIET: assert property (
      (s_ff.phase == PH_RUN && s_ff.nq == MIN_QUEUES) |=> ##1
      (almost_empty_flag_bus_out[3:1] == 3'h0 && almost_full_flag_bus_out[3:1] == 3'h0))
      else $error("flag bus active for an unused queue");

   AST_DEFAULT_LAYOUT: assert property (
      (s_ff.phase == PH_CAPTURE && cfg_default_in)
      |=> (s_ff.nq == DEFAULT_QUEUES && s_ff.blocks == {NUM_Q{DEFAULT_BLOCKS}}))
      else $error("default layout not taken");

   AST_FULL_NO_ROOM: assert property (
      (s_ff.phase == PH_RUN && {1'b0, wq} < s_ff.nq && !single_queue_reset)
      |=> ((wq != $past(wq)) ||
           (write_queue_full_flag_out == ((qs.cap[wq] - s_ff.cnt[wq]) < wbytes))))
      else $error("full flag disagrees with queue room");

   COV_FULL:      cover property (write_queue_full_flag_out && wr_en_in);
   COV_BACK2BACK: cover property (pop ##1 pop ##1 pop);
   COV_SWITCH:    cover property (output_valid_flag_out ##1 !output_valid_flag_out && $changed(rq));
   COV_PRS:       cover property (single_queue_reset && s_ff.cnt[wq] != '0);

endmodule : multi_queue_flow_fifo

`default_nettype wire

// >>> design/mq_fifo_pkg.sv
// mq_fifo_pkg: constants, types and helpers of the multi-queue fifo
// assumes one clock domain and one shared pool addressed in 9-bit units
//
// Overview of operation
// - one to four queues share one pool
// - layout set at reset, whole blocks
// - writer addresses queue, word steered there
// - reader addresses queue, word taken there
// - write and read ports act independently
// - full for write queue, valid for read
// - per-queue almost flags, programmable levels
// - two 4-bit almost flag buses
// - each port 9 or 18 bits wide
// - width conversion keeps little-endian order
// - layout and levels from config pins or built-in defaults
// - default layout: four equal queues
// - master reset captures configuration pins
// - partial reset clears one shared-addressed queue
// - a write and read every cycle
// - next word falls through unasked
// - up to eight devices in parallel
// - empty queue switch keeps last word
// - 1,024 x 9 only if both narrow

package mq_fifo_pkg;

   localparam int               NUM_Q          = 4;
   localparam int               QSEL_W         = 2;
   localparam int               DATA_W         = 18;
   localparam int               BYTE_W         = 9;
   localparam int               PTR_W          = 17;
   localparam int               BLK_W          = 7;
   localparam int               NQ_W           = 3;
   localparam int               DEV_W          = 3;
   localparam int               ADDR_W         = 15;
   localparam int               POOL_WORDS     = 32768;
   localparam int               BLK_SHIFT      = 10;
   localparam logic [BLK_W-1:0] TOTAL_BLOCKS   = 7'h40;
   localparam logic [PTR_W-1:0] BLOCK_BYTES    = 17'h00400;
   localparam logic [PTR_W-1:0] WIDE_BLK_WORDS = 17'h00200;
   localparam logic [PTR_W-1:0] NARR_BLK_WORDS = 17'h00400;
   localparam logic [PTR_W-1:0] WIDE_BYTES     = 17'h00002;
   localparam logic [PTR_W-1:0] NARR_BYTES     = 17'h00001;
   localparam logic [NQ_W-1:0]  MIN_QUEUES     = 3'h1;
   localparam logic [NQ_W-1:0]  MAX_QUEUES     = 3'h4;
   localparam logic [NQ_W-1:0]  DEFAULT_QUEUES = 3'h4;
   localparam logic [BLK_W-1:0] DEFAULT_BLOCKS = 7'h10;
   localparam logic [PTR_W-1:0] DEFAULT_AE     = 17'h00010;
   localparam logic [PTR_W-1:0] DEFAULT_AF     = 17'h00010;
   localparam logic [BYTE_W-1:0] ZERO_BYTE     = 9'h000;

   typedef enum logic {PH_CAPTURE, PH_RUN} phase_t;
   typedef logic [NUM_Q-1:0][PTR_W-1:0] qvec_t;
   typedef logic [NUM_Q-1:0][BLK_W-1:0] bvec_t;

   // bytes moved per beat of a port
   function automatic logic [PTR_W-1:0] unit_bytes(input logic wide);
      return wide ? WIDE_BYTES : NARR_BYTES;
   endfunction : unit_bytes

   // pointer step with wrap at the queue's end
   function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
                                                input logic [PTR_W-1:0] n,
                                                input logic [PTR_W-1:0] cap);
      logic [PTR_W:0] sum;
      sum = {1'b0, p} + {1'b0, n};
      return (sum >= {1'b0, cap}) ? '0 : sum[PTR_W-1:0];
   endfunction : step_ptr

   // words in one block for the chosen widths
   function automatic logic [PTR_W-1:0] block_words(input logic in_wide,
                                                   input logic out_wide);
      return (in_wide || out_wide) ? WIDE_BLK_WORDS : NARR_BLK_WORDS;
   endfunction : block_words

endpackage : mq_fifo_pkg

// >>> design/qstat_if.sv
// qstat_if: queue layout and level state shared by the fifo core and helpers
// assumes all members are driven in the mclk_in domain
`timescale 1ns/100ps
`default_nettype none

interface qstat_if;
   import mq_fifo_pkg::*;
   logic [NQ_W-1:0]  nq;
   bvec_t            blocks;
   qvec_t            cnt;
   qvec_t            ae_lvl;
   qvec_t            af_lvl;
   qvec_t            base;
   qvec_t            cap;
   logic [NUM_Q-1:0] af;
   logic [NUM_Q-1:0] ae;

   modport core   (output nq, blocks, cnt, ae_lvl, af_lvl, input base, cap, af, ae);
   modport layout (input nq, blocks, output base, cap);
   modport flags  (input nq, cnt, cap, ae_lvl, af_lvl, output af, ae);
endinterface : qstat_if

`default_nettype wire

// >>> design/queue_layout.sv
// queue_layout: carves the pool into per-queue base and size in 9-bit units
// assumes the host keeps the block total within the pool
`timescale 1ns/100ps
`default_nettype none

module queue_layout (
   qstat_if.layout qs
);
   import mq_fifo_pkg::*;

   always_comb begin
      logic [PTR_W-1:0] run;
      run = '0;
      for (int i = 0; i < NUM_Q; i++) begin
         // blocks stacked in queue order
         qs.base[i] = run;
         qs.cap[i]  = (i < int'(qs.nq)) ? {qs.blocks[i], 10'h000} : '0;
         run        = run + qs.cap[i];
      end
   end

endmodule : queue_layout

`default_nettype wire

// >>> design/queue_flags.sv
// queue_flags: almost-full and almost-empty compare for every queue
// assumes counts and levels share the same 9-bit unit
`timescale 1ns/100ps
`default_nettype none

module queue_flags (
   qstat_if.flags qs
);
   import mq_fifo_pkg::*;

   always_comb begin
      for (int i = 0; i < NUM_Q; i++) begin
         // unused queues stay quiet on both buses
         qs.ae[i] = (i < int'(qs.nq)) && (qs.cnt[i] <= qs.ae_lvl[i]);
         qs.af[i] = (i < int'(qs.nq)) &&
                    (({1'b0, qs.cnt[i]} + {1'b0, qs.af_lvl[i]}) >= {1'b0, qs.cap[i]});
      end
   end

endmodule : queue_flags

`default_nettype wire

// >>> tb/host_port_model.sv
// host_port_model: writer and reader host logic on the fifo's two ports
// assumes the fifo samples all inputs on rising edges of mclk_in
`timescale 1ns/100ps
`default_nettype none

module host_port_model (
   input  wire logic                           mclk_in,
   input  wire logic                           full_in,
   input  wire logic                           valid_in,
   input  wire logic [mq_fifo_pkg::DATA_W-1:0] rd_data_in,
   output logic                                wr_en_out,
   output logic [mq_fifo_pkg::QSEL_W-1:0]      wq_out,
   output logic [mq_fifo_pkg::DATA_W-1:0]      wd_out,
   output logic                                rd_en_out,
   output logic [mq_fifo_pkg::QSEL_W-1:0]      rq_out,
   output logic                                qrst_out
);
   import mq_fifo_pkg::*;

   initial begin
      wr_en_out = 1'b0;
      wq_out    = 2'h0;
      wd_out    = 18'h00000;
      rd_en_out = 1'b0;
      rq_out    = 2'h0;
      qrst_out  = 1'b0;
   end

   //////////////////////////////////////////////////////////////
   // one beat per call; back-to-back calls keep the enable up
   task automatic put(input logic [QSEL_W-1:0] q, input logic [DATA_W-1:0] d,
                      input logic refuse_ok);
      @(posedge mclk_in);
      #1;
      wq_out    = q;
      wd_out    = d;
      wr_en_out = refuse_ok | ~full_in;
   endtask : put

   // released data bus shows the inverse, not a stale word
   task automatic idle_w();
      @(posedge mclk_in);
      #1;
      wr_en_out = 1'b0;
      wd_out    = ~wd_out;
   endtask : idle_w

   task automatic sel_rd(input logic [QSEL_W-1:0] q);
      @(posedge mclk_in);
      #1;
      rq_out = q;
   endtask : sel_rd

   // bounded wait for a presented word, then take it for one edge
   task automatic take(output logic ok, output logic [DATA_W-1:0] d);
      ok = 1'b0;
      d  = 18'h00000;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge mclk_in);
         #1;
         ok = (valid_in === 1'b1);
         d  = rd_data_in;
      end
      if (ok) begin
         rd_en_out = 1'b1;
         @(posedge mclk_in);
         #1;
         rd_en_out = 1'b0;
      end
   endtask : take

   // read enable held up for n edges: one word taken per cycle
   task automatic burst(input int n);
      @(posedge mclk_in);
      #1;
      rd_en_out = 1'b1;
      repeat (n) @(posedge mclk_in);
      #1;
      rd_en_out = 1'b0;
   endtask : burst

   // both ports on the same queue while the clear is up
   task automatic clr(input logic [QSEL_W-1:0] q);
      @(posedge mclk_in);
      #1;
      wq_out   = q;
      rq_out   = q;
      qrst_out = 1'b1;
      @(posedge mclk_in);
      #1;
      qrst_out = 1'b0;
   endtask : clr
endmodule : host_port_model

`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: directed bench driving the multi-queue fifo through the host model
// assumes one 100 MHz clock and config pins captured at reset release
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import mq_fifo_pkg::*;

   logic                        mclk_in, nrst_in, cfg_def, in_w, out_w;
   logic [NQ_W-1:0]             cfg_nq;
   logic [3:0][BLK_W-1:0]       blks;
   logic [3:0][PTR_W-1:0]       ae_lvl, af_lvl;
   logic [DEV_W-1:0]            wr_dsel, rd_dsel, dev_id;
   logic                        wr_en, rd_en, qrst, done, valid, full, af, ae, ok;
   logic [QSEL_W-1:0]           wq, rq;
   logic [DATA_W-1:0]           wd, rdata, d;
   logic [3:0]                  af_bus, ae_bus;
   logic [PTR_W-1:0]            bw;
   int                          failures, cmp_count;

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   multi_queue_flow_fifo DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .cfg_default_in(cfg_def), .cfg_queues_in(cfg_nq), .cfg_blocks_in(blks),
      .cfg_ae_level_in(ae_lvl), .cfg_af_level_in(af_lvl), .in_wide_in(in_w),
      .out_wide_in(out_w), .device_id_in(dev_id), .write_device_select_in(wr_dsel),
      .read_device_select_in(rd_dsel), .wr_en_in(wr_en), .write_queue_select_in(wq),
      .wr_data_in(wd), .rd_en_in(rd_en), .read_queue_select_in(rq),
      .single_queue_reset_in(qrst), .config_done_out(done), .rd_data_out(rdata),
      .output_valid_flag_out(valid), .write_queue_full_flag_out(full),
      .almost_full_flag_out(af), .almost_empty_flag_out(ae),
      .almost_full_flag_bus_out(af_bus), .almost_empty_flag_bus_out(ae_bus),
      .block_words_out(bw));

   host_port_model host (.mclk_in(mclk_in), .full_in(full), .valid_in(valid),
      .rd_data_in(rdata), .wr_en_out(wr_en), .wq_out(wq), .wd_out(wd),
      .rd_en_out(rd_en), .rq_out(rq), .qrst_out(qrst));

   //////////////////////////////////////////////////////////////
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc

   // pins held steady across release; first access two edges later
   task automatic mreset(input logic dflt, input logic [NQ_W-1:0] nq,
                         input logic iw, input logic ow);
      nrst_in = 1'b0;
      cfg_def = dflt;
      cfg_nq  = nq;
      in_w    = iw;
      out_w   = ow;
      cyc(5);
      nrst_in = 1'b1;
      cyc(2);
   endtask : mreset

   task automatic rd(input logic [DATA_W-1:0] exp);
      host.take(ok, d);
      chk(ok, 1'b1);
      chk(d, exp);
   endtask : rd

   task automatic stop_test();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   //////////////////////////////////////////////////////////////
   initial begin
      failures  = 0;
      cmp_count = 0;
      blks      = {4{7'h01}};
      ae_lvl    = {4{17'h00010}};
      af_lvl    = {4{17'h00010}};
      wr_dsel   = 3'h0;
      rd_dsel   = 3'h0;
      dev_id    = 3'h0;
      mreset(1'b0, 3'h7, 1'b1, 1'b1);  // count above four clamps to four
      chk(done, 1'b1);
      chk(bw, 18'h00200);
      chk(ae_bus, 4'hF);
      chk(af_bus, 4'h0);
      host.sel_rd(2'h0);
      cyc(1);
      chk(ae, 1'b1);
      host.put(2'h0, 18'h12345, 1'b0);
      host.idle_w();
      rd(18'h12345);
      chk(valid, 1'b0);
      host.put(2'h1, 18'h0A001, 1'b0);
      host.put(2'h2, 18'h0B002, 1'b0);
      host.idle_w();
      host.sel_rd(2'h2);
      rd(18'h0B002);
      fork
         begin
            host.put(2'h2, 18'h0C003, 1'b0);
            host.idle_w();
         end
         begin
            host.sel_rd(2'h1);
            rd(18'h0A001);
         end
      join
      host.sel_rd(2'h2);
      rd(18'h0C003);
      host.sel_rd(2'h3);
      cyc(3);
      chk(rdata, 18'h0C003);
      chk(valid, 1'b0);
      wr_dsel = 3'h1;
      host.put(2'h0, 18'h0BEEF, 1'b0);
      host.idle_w();
      wr_dsel = 3'h0;
      host.sel_rd(2'h0);
      cyc(4);
      chk(valid, 1'b0);
      for (int i = 0; i < 512; i++) host.put(2'h3, 18'(i), 1'b0);
      host.idle_w();
      cyc(1);
      chk(full, 1'b1);
      chk(af, 1'b1);
      chk(af_bus, 4'h8);
      chk(ae_bus, 4'h7);
      host.put(2'h3, 18'h3FFFF, 1'b1);
      host.idle_w();
      host.sel_rd(2'h3);
      cyc(2);
      chk(ae, 1'b0);
      for (int i = 0; i < 512; i++) rd(18'(i));
      chk(valid, 1'b0);
      chk(full, 1'b0);
      for (int i = 0; i < 20; i++) host.put(2'h1, 18'h00100 + 18'(i), 1'b0);
      host.idle_w();
      cyc(2);
      chk(ae_bus[1], 1'b0);
      host.clr(2'h1);
      cyc(2);
      chk(ae_bus[1], 1'b1);
      host.put(2'h1, 18'h2A5A5, 1'b0);
      host.idle_w();
      rd(18'h2A5A5);
      mreset(1'b0, 3'h4, 1'b0, 1'b1);
      chk(bw, 18'h00200);
      host.put(2'h0, 18'h000AB, 1'b0);
      host.put(2'h0, 18'h001CD, 1'b0);
      host.idle_w();
      host.sel_rd(2'h0);
      rd({9'h1CD, 9'h0AB});
      mreset(1'b0, 3'h2, 1'b1, 1'b0);
      chk(ae_bus, 4'h3);
      host.put(2'h0, {9'h155, 9'h0AA}, 1'b0);
      host.idle_w();
      rd(18'h000AA);
      rd(18'h00155);
      // zero queues clamps to one; own levels, two blocks, device number five
      dev_id    = 3'h5;
      wr_dsel   = 3'h5;
      rd_dsel   = 3'h2;
      blks[0]   = 7'h02;
      ae_lvl[0] = 17'h00002;
      af_lvl[0] = 17'h007FC;
      mreset(1'b0, 3'h0, 1'b1, 1'b1);
      chk(ae_bus, 4'h1);
      host.put(2'h0, 18'h15A5A, 1'b0);
      host.idle_w();
      cyc(2);
      chk({af_bus, ae_bus}, 8'h01);
      host.put(2'h0, 18'h2C3C3, 1'b0);
      host.put(2'h0, 18'h0F00F, 1'b0);
      host.idle_w();
      cyc(2);
      chk({af_bus, ae_bus}, 8'h10);
      host.take(ok, d);
      cyc(2);
      chk(rdata, 18'h15A5A);
      rd_dsel = 3'h5;
      host.burst(3);
      chk(rdata, 18'h0F00F);
      chk(valid, 1'b0);
      mreset(1'b1, 3'h1, 1'b0, 1'b0);
      chk(bw, 18'h00400);
      chk(ae_bus, 4'hF);
      host.put(2'h3, 18'h00077, 1'b0);
      host.idle_w();
      host.sel_rd(2'h3);
      rd(18'h00077);
      stop_test();
   end

   // run needs well under 10k cycles; this cuts a hang short
   initial begin
      #400000;
      failures++;
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
